//--- rais_pkg.sv
// rais_pkg: constants for the reset and interrupt sequencer.
// assumes one 100 MHz clock equal to the cpu cycle clock.
package rais_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 10;
  localparam int TCYC_NS = 10;
  localparam int STARTUP_XTAL_TCYC = 4064;
  localparam int STARTUP_FAST_TCYC = 2;
  localparam logic [11:0] STARTUP_XTAL_CNT = 12'(STARTUP_XTAL_TCYC * TCYC_NS / CLK_NS);
  localparam logic [11:0] STARTUP_FAST_CNT = 12'(STARTUP_FAST_TCYC * TCYC_NS / CLK_NS);
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [11:0] CNT_ZERO = 12'h000;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and vectors
  localparam logic [15:0] TIMER_RESET_COUNT = 16'hFFFC;
  localparam logic [12:0] SP_RESET = 13'h00FF;
  localparam logic [12:0] VEC_RESET = 13'h1FFE;
  localparam logic [12:0] VEC_TRAP = 13'h1FFC;
  localparam logic [12:0] VEC_EXT = 13'h1FFA;
  localparam logic [12:0] VEC_TIMER = 13'h1FF8;
  localparam logic [12:0] VEC_SERIAL = 13'h1FF4;
  localparam logic [12:0] VEC_PORT_B = 13'h1FF2;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SPECIAL = 8'h04;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h08;
  localparam logic [7:0] OFS_TMR_STAT = 8'h0C;
  localparam logic [7:0] OFS_SER_CTRL = 8'h10;
  localparam logic [7:0] OFS_SER_STAT = 8'h14;
  localparam logic [7:0] OFS_TMR_DATA = 8'h18;
  localparam logic [7:0] OFS_SER_DATA = 8'h1C;
  localparam logic [7:0] OFS_PORT_B = 8'h20;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h24;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int B_PORT_A_OPEN_DRAIN = 0;
  localparam int B_PBIE = 1;
  localparam int B_DLY = 2;
  localparam int B_PORT_B_IRQ_FLAG = 7;
  localparam int B_TMR_LSB = 5;
  localparam int B_COMPARE_OUTPUT_LEVEL = 0;
  localparam int B_SIE = 7;
  localparam int B_SEN = 6;
  localparam int B_SOD = 5;
  localparam int B_SMS = 4;
  localparam int B_SDONE = 7;
  localparam int B_SWCOL = 6;
  localparam int B_SMODF = 4;
  localparam int B_TOSC = 0;
  localparam int B_TEXT = 1;
  localparam int B_ST_GMASK = 3;
  localparam int B_ST_EXT = 4;
  localparam int B_ST_RST = 5;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer states, gray along timeout, hold, vector, run
  typedef enum logic [2:0] {
    ST_TIMEOUT = 3'h0,
    ST_HOLD = 3'h1,
    ST_VECTOR = 3'h3,
    ST_RUN = 3'h2,
    ST_STACK = 3'h6,
    ST_WAIT = 3'h7,
    ST_STOP = 3'h5
  } rais_state_type;

endpackage

//--- rais_flag_if.sv
// rais_flag_if: event, access and flag bundle between sequencer and flag bank.
// assumes both ends on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rais_flag_if #(parameter int W = 1);
  logic [W-1:0] set_ev;
  logic status_acc;
  logic assoc_acc;
  logic init;
  logic [W-1:0] flag;
  modport owner (input set_ev, input status_acc, input assoc_acc, input init, output flag);
  modport user (output set_ev, output status_acc, output assoc_acc, output init, input flag);
endinterface
`default_nettype wire

//--- rais_flag.sv
// rais_flag: bank of sticky interrupt flags with two-step software clear.
// assumes access strobes are one-cycle pulses from the bus slave.
`timescale 1ns/100ps
`default_nettype none
module rais_flag #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  rais_flag_if.owner fl
);

  logic [W-1:0] armed;

  //////////////////////////////////////////////////////////////////////////////
  // a flag is armed by a status access while set, cleared by a later
  // access of its associated register; a new event wins if it lands on either access, but is cleared if it lands between them
  always_ff @(posedge clk) begin
    if (sys_rst || fl.init) begin
      fl.flag <= '0;
    end else begin
      fl.flag <= fl.set_ev | (fl.flag & ~({W{fl.assoc_acc}} & armed)); // RULE12
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || fl.init) begin
      armed <= '0;
    end else if (fl.status_acc) begin
      armed <= fl.flag & ~fl.set_ev; // RULE12
    end else if (fl.assoc_acc) begin
      armed <= '0;
    end
  end

endmodule
`default_nettype wire

//--- rais_sequencer.sv
// rais_sequencer: reset, start-up timeout and interrupt sequencing for the core.
// assumes cpu strobes arrive synchronous to clk; one ahb-lite master.
//
// How it works
// RULE1: reset pin held low 1.5 cycles minimum
// RULE2: start-up timeout 4064 or 2 by option
// RULE3: delay override forces two-cycle stop exit
// RULE4: stay in reset while pin still low
// RULE5: reset clears timer controls, loads counter $FFFC
// RULE6: reset clears ddr, sp $00FF, mask, vector
// RULE7: reset clears stop, external, wait latches
// RULE8: reset disables serial interface, slave mode
// RULE9: reset stops timer oscillator, clears port bits
// RULE10: four maskable sources plus software trap
// RULE11: enable blocks request, not flag setting
// RULE12: flag clears after status then data access
// RULE13: take at instruction end, stack, mask, vector
// RULE14: return restores mask from stacked value
// RULE15: priority reset, trap, external, timer, serial, port b
// RULE16: vectors reset 1FFE, trap 1FFC, external 1FFA
// RULE17: vectors timer 1FF8, serial 1FF4, port b 1FF2
// RULE18: several flags share one source vector
// RULE19: stop halts oscillator until wake source
// RULE20: wait ends through normal vectors
// RULE21: trap ignores mask, vectors through 1FFC
// RULE22: stop and wait clear the global mask
// RULE23: stop wake completes timeout before vector
`timescale 1ns/100ps
`default_nettype none
module rais_sequencer
  import rais_pkg::*;
#(
  parameter bit CRYSTAL_OPTION = 1'b1,
  parameter bit LEVEL_TRIGGER = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic ext_irq_n,
  input wire logic insn_end,
  input wire logic exec_swi,
  input wire logic exec_rti,
  input wire logic rti_stacked_mask,
  input wire logic exec_stop,
  input wire logic exec_wait,
  input wire logic capture_event,
  input wire logic compare_event,
  input wire logic overflow_event,
  input wire logic transfer_done_event,
  input wire logic write_collision_event,
  input wire logic mode_fault_event,
  input wire logic port_b_interrupt,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic cpu_reset,
  output logic cpu_run,
  output logic osc_enable,
  output logic stack_push,
  output logic vector_fetch,
  output logic [12:0] vector_addr,
  output logic [12:0] sp_value,
  output logic [15:0] timer_preset,
  output logic global_mask_bit,
  output logic compare_output_pin,
  output logic compare_output_level,
  output logic serial_enable,
  output logic serial_master_select,
  output logic serial_open_drain,
  output logic port_a_open_drain,
  output logic timer_osc_enable,
  output logic timer_osc_oe_n
);

  rais_state_type state;
  logic [11:0] tmo_cnt, reset_cnt, stop_cnt;
  logic [7:0] dp_addr, acc_addr;
  logic [2:0] tmr_en;
  logic [12:0] hw_vec;
  logic [31:0] rd_mux;
  logic from_stop, ext_latch, ext_prev, timer_ext_clk, dp_wr, reset_req, bus_acc;
  logic serial_irq_enable, port_b_irq_enable, startup_delay_override;
  logic tmr_req, ser_req, pb_req, any_hw, stop_wake, take;
  rais_flag_if #(.W(3)) tmr_fl ();
  rais_flag_if #(.W(3)) ser_fl ();
  rais_flag_if #(.W(1)) pb_fl ();

  //////////////////////////////////////////////////////////////////////////////
  // request logic
  assign reset_req = !rst_pin_n;
  assign tmr_req = |(tmr_fl.flag & tmr_en); // RULE11 RULE18
  assign ser_req = serial_irq_enable & (ser_fl.flag[2] | ser_fl.flag[0]); // RULE18
  assign pb_req = port_b_irq_enable & pb_fl.flag[0]; // RULE11
  assign any_hw = ext_latch | tmr_req | ser_req | pb_req; // RULE10
  // timer wakes stop only when clocked from outside, the cpu clock is off
  assign stop_wake = ext_latch | pb_req | (tmr_req & timer_ext_clk); // RULE19
  assign reset_cnt = CRYSTAL_OPTION ? STARTUP_XTAL_CNT : STARTUP_FAST_CNT; // RULE2
  assign stop_cnt = startup_delay_override ? STARTUP_FAST_CNT : reset_cnt; // RULE3

  // software trap is the current instruction, so it beats every source
  assign take = (state == ST_RUN && insn_end && (exec_swi || (!global_mask_bit && any_hw)))
             || (state == ST_WAIT && any_hw); // RULE13 RULE20 RULE21
  assign hw_vec = ext_latch ? VEC_EXT : tmr_req ? VEC_TIMER // RULE15 RULE16
                : ser_req ? VEC_SERIAL : VEC_PORT_B; // RULE15 RULE17

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_TIMEOUT;
      tmo_cnt <= reset_cnt - CNT_ONE; // RULE2
      from_stop <= 1'b0;
    end else if (reset_req && !cpu_reset) begin
      state <= ST_TIMEOUT; // RULE7
      tmo_cnt <= reset_cnt - CNT_ONE;
      from_stop <= 1'b0;
    end else begin
      case (state)
        ST_TIMEOUT: begin
          if (tmo_cnt != CNT_ZERO) begin
            tmo_cnt <= tmo_cnt - CNT_ONE;
          end else if (from_stop) begin
            state <= ST_WAIT; // RULE23
          end else if (reset_req) begin
            state <= ST_HOLD; // RULE4
          end else begin
            state <= ST_VECTOR;
          end
        end
        ST_HOLD: begin
          if (!reset_req) begin
            state <= ST_VECTOR; // RULE4
          end
        end
        ST_VECTOR: begin
          state <= ST_RUN;
        end
        ST_RUN: begin
          if (take) begin
            state <= ST_STACK;
          end else if (insn_end && exec_stop) begin
            state <= ST_STOP;
          end else if (insn_end && exec_wait) begin
            state <= ST_WAIT;
          end
        end
        ST_STACK: begin
          state <= ST_RUN;
        end
        ST_WAIT: begin
          if (take) begin
            state <= ST_STACK; // RULE20
          end
        end
        ST_STOP: begin
          if (stop_wake) begin
            state <= ST_TIMEOUT; // RULE19 RULE23
            tmo_cnt <= stop_cnt - CNT_ONE; // RULE3
            from_stop <= 1'b1;
          end
        end
        default: begin
          state <= ST_TIMEOUT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cpu-facing outputs
  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      cpu_reset <= 1'b1; // RULE6
      cpu_run <= 1'b0;
      osc_enable <= 1'b1;
    end else begin
      cpu_reset <= (state == ST_TIMEOUT && !from_stop) || state == ST_HOLD;
      cpu_run <= (state == ST_RUN && !take && !(insn_end && (exec_stop || exec_wait)))
              || state == ST_STACK || state == ST_VECTOR; // RULE20
      osc_enable <= !(state == ST_RUN && !take && insn_end && exec_stop)
                 && !(state == ST_STOP && !stop_wake); // RULE19
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      stack_push <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= VEC_RESET; // RULE6 RULE16
    end else begin
      stack_push <= take; // RULE13
      vector_fetch <= state == ST_STACK || state == ST_VECTOR;
      if (take) begin
        vector_addr <= (state == ST_RUN && exec_swi) ? VEC_TRAP : hw_vec; // RULE15 RULE21
      end else if (state == ST_HOLD || state == ST_TIMEOUT) begin
        vector_addr <= VEC_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      global_mask_bit <= 1'b1; // RULE6
    end else if (take) begin
      global_mask_bit <= 1'b1; // RULE13
    end else if (state == ST_RUN && insn_end && (exec_stop || exec_wait)) begin
      global_mask_bit <= 1'b0; // RULE22
    end else if (state == ST_RUN && insn_end && exec_rti) begin
      global_mask_bit <= rti_stacked_mask; // RULE14
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      sp_value <= SP_RESET; // RULE6
      timer_preset <= TIMER_RESET_COUNT; // RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external interrupt latch, edge or level by option
  always_ff @(posedge clk) begin
    ext_prev <= sys_rst ? 1'b1 : ext_irq_n;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      ext_latch <= 1'b0; // RULE7
    end else if ((ext_prev && !ext_irq_n) || (LEVEL_TRIGGER && !ext_irq_n)) begin
      ext_latch <= 1'b1;
    end else if (take && hw_vec == VEC_EXT && !(state == ST_RUN && exec_swi)) begin
      ext_latch <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, reads latched in the address phase
  assign bus_acc = hsel && htrans[1] && hready;
  assign acc_addr = haddr[7:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_wr <= 1'b0;
      dp_addr <= OFS_STATUS;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      dp_wr <= bus_acc && hwrite;
      dp_addr <= acc_addr;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (acc_addr == OFS_STATUS) begin
      rd_mux[2:0] = state;
      rd_mux[B_ST_GMASK] = global_mask_bit;
      rd_mux[B_ST_EXT] = ext_latch;
      rd_mux[B_ST_RST] = cpu_reset;
    end else if (acc_addr == OFS_SPECIAL) begin
      rd_mux[B_PORT_B_IRQ_FLAG] = pb_fl.flag[0];
      rd_mux[B_DLY] = startup_delay_override;
      rd_mux[B_PBIE] = port_b_irq_enable;
      rd_mux[B_PORT_A_OPEN_DRAIN] = port_a_open_drain;
    end else if (acc_addr == OFS_TMR_CTRL) begin
      rd_mux[B_TMR_LSB +: 3] = tmr_en;
      rd_mux[B_COMPARE_OUTPUT_LEVEL] = compare_output_level;
    end else if (acc_addr == OFS_TMR_STAT) begin
      rd_mux[B_TMR_LSB +: 3] = tmr_fl.flag;
    end else if (acc_addr == OFS_SER_CTRL) begin
      rd_mux[B_SIE] = serial_irq_enable;
      rd_mux[B_SEN] = serial_enable;
      rd_mux[B_SOD] = serial_open_drain;
      rd_mux[B_SMS] = serial_master_select;
    end else if (acc_addr == OFS_SER_STAT) begin
      rd_mux[B_SDONE] = ser_fl.flag[2];
      rd_mux[B_SWCOL] = ser_fl.flag[1];
      rd_mux[B_SMODF] = ser_fl.flag[0];
    end else if (acc_addr == OFS_CLK_CTRL) begin
      rd_mux[B_TOSC] = timer_osc_enable;
      rd_mux[B_TEXT] = timer_ext_clk;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (bus_acc && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers, cleared by either reset
  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      tmr_en <= 3'h0; // RULE5
      compare_output_level <= 1'b0; // RULE5
      serial_irq_enable <= 1'b0; // RULE8
      serial_enable <= 1'b0; // RULE8
      serial_master_select <= 1'b0; // RULE8
      serial_open_drain <= 1'b0; // RULE9
      port_b_irq_enable <= 1'b0; // RULE9
      port_a_open_drain <= 1'b0; // RULE9
      startup_delay_override <= 1'b0; // RULE3 RULE9
      timer_osc_enable <= 1'b0; // RULE9
      timer_ext_clk <= 1'b0; // RULE9
    end else if (dp_wr) begin
      if (dp_addr == OFS_SPECIAL) begin
        startup_delay_override <= hwdata[B_DLY];
        port_b_irq_enable <= hwdata[B_PBIE];
        port_a_open_drain <= hwdata[B_PORT_A_OPEN_DRAIN];
      end else if (dp_addr == OFS_TMR_CTRL) begin
        tmr_en <= hwdata[B_TMR_LSB +: 3];
        compare_output_level <= hwdata[B_COMPARE_OUTPUT_LEVEL];
      end else if (dp_addr == OFS_SER_CTRL) begin
        serial_irq_enable <= hwdata[B_SIE];
        serial_enable <= hwdata[B_SEN];
        serial_open_drain <= hwdata[B_SOD];
        serial_master_select <= hwdata[B_SMS];
      end else if (dp_addr == OFS_CLK_CTRL) begin
        timer_osc_enable <= hwdata[B_TOSC];
        timer_ext_clk <= hwdata[B_TEXT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || reset_req) begin
      compare_output_pin <= 1'b0; // RULE5
      timer_osc_oe_n <= 1'b1; // RULE9
    end else begin
      timer_osc_oe_n <= !timer_osc_enable;
      if (compare_event) begin
        compare_output_pin <= compare_output_level;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag banks; port b clears only on a read of its data
  assign tmr_fl.set_ev = {capture_event, compare_event, overflow_event};
  assign tmr_fl.status_acc = bus_acc && acc_addr == OFS_TMR_STAT; // RULE12
  assign tmr_fl.assoc_acc = bus_acc && acc_addr == OFS_TMR_DATA;
  assign tmr_fl.init = reset_req;
  assign ser_fl.set_ev = {transfer_done_event, write_collision_event, mode_fault_event};
  assign ser_fl.status_acc = bus_acc && acc_addr == OFS_SER_STAT;
  assign ser_fl.assoc_acc = bus_acc && acc_addr == OFS_SER_DATA;
  assign ser_fl.init = reset_req; // RULE8
  assign pb_fl.set_ev = port_b_interrupt;
  assign pb_fl.status_acc = bus_acc && acc_addr == OFS_SPECIAL;
  assign pb_fl.assoc_acc = bus_acc && !hwrite && acc_addr == OFS_PORT_B;
  assign pb_fl.init = reset_req;
  rais_flag #(.W(3)) u_tmr_flags (.clk(clk), .sys_rst(sys_rst), .fl(tmr_fl));
  rais_flag #(.W(3)) u_ser_flags (.clk(clk), .sys_rst(sys_rst), .fl(ser_fl));
  rais_flag #(.W(1)) u_pb_flags (.clk(clk), .sys_rst(sys_rst), .fl(pb_fl));

endmodule
`default_nettype wire

//--- rais_sequencer_chk.sv
// rais_sequencer_chk: port-level assertions for the reset and interrupt sequencer.
// assumes one clock domain and sys_rst synchronous, active high.
`timescale 1ns/100ps
`default_nettype none
module rais_sequencer_chk
  import rais_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic insn_end,
  input wire logic exec_swi,
  input wire logic exec_rti,
  input wire logic rti_stacked_mask,
  input wire logic exec_stop,
  input wire logic exec_wait,
  input wire logic cpu_reset,
  input wire logic cpu_run,
  input wire logic osc_enable,
  input wire logic stack_push,
  input wire logic vector_fetch,
  input wire logic [12:0] vector_addr,
  input wire logic [12:0] sp_value,
  input wire logic [15:0] timer_preset,
  input wire logic global_mask_bit,
  input wire logic compare_output_pin,
  input wire logic compare_output_level,
  input wire logic serial_enable,
  input wire logic serial_master_select,
  input wire logic serial_open_drain,
  input wire logic port_a_open_drain,
  input wire logic timer_osc_enable
);
  // insn_end only counts in plain run, not in the take sequence itself
  logic run_ok;
  assign run_ok = cpu_run && !cpu_reset && !stack_push && !vector_fetch;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  a_push_then_fetch: assert property (stack_push |=> vector_fetch && vector_addr != VEC_RESET)
    else $error("vector fetch did not follow stack push");
  a_push_sets_mask: assert property (stack_push |-> global_mask_bit)
    else $error("mask not set with stack push");
  a_trap_vector: assert property (insn_end && exec_swi && run_ok |=>
    stack_push ##1 (vector_fetch && vector_addr == VEC_TRAP))
    else $error("trap not stacked and vectored");
  a_rti_restore: assert property (insn_end && exec_rti && !exec_swi && !exec_stop && !exec_wait
    && run_ok |=> global_mask_bit == $past(rti_stacked_mask))
    else $error("return did not restore mask");
  a_pin_hold_reset: assert property (!rst_pin_n |=> cpu_reset && !cpu_run && !vector_fetch)
    else $error("core left reset while pin low");
  a_pin_clear_ctrl: assert property (!rst_pin_n |=> !compare_output_pin && !compare_output_level
    && !serial_enable && !serial_master_select && !serial_open_drain && !port_a_open_drain
    && !timer_osc_enable && timer_preset == TIMER_RESET_COUNT)
    else $error("control bits not cleared by pin reset");
  a_pin_reset_core: assert property (!rst_pin_n |=> global_mask_bit && sp_value == SP_RESET
    && vector_addr == VEC_RESET)
    else $error("core state not reset by pin");
  a_stop_osc_off: assert property (insn_end && exec_stop && !exec_swi && run_ok |->
    ##[1:3] (!osc_enable && !global_mask_bit && !cpu_run))
    else $error("stop did not halt oscillator");
  a_mask_blocks: assert property (global_mask_bit && !(insn_end && exec_swi) |=> !stack_push)
    else $error("interrupt taken while masked");
  a_reset_vector: assert property ($fell(cpu_reset) |-> vector_fetch && vector_addr == VEC_RESET)
    else $error("reset exit without reset vector");
endmodule
bind rais_sequencer rais_sequencer_chk rais_sequencer_chk_inst (.*);
`default_nettype wire

//--- rais_partner.sv
// rais_partner: external reset circuit and on-chip interrupt sources.
// assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module rais_partner (
  input wire logic clk,
  output logic rst_pin_n,
  output logic ext_irq_n,
  output logic [6:0] ev
);
  initial begin
    rst_pin_n = 1'b1;
    ext_irq_n = 1'b1;
    ev = 7'h00;
  end
  // never shorter than two cycles, so the pin always clears the minimum width
  task automatic pin_reset(input int n);
    @(posedge clk) rst_pin_n <= 1'b0;
    repeat ((n < 2) ? 2 : n) @(posedge clk);
    rst_pin_n <= 1'b1;
  endtask
  // short pulse: released before service so level trigger does not relatch
  task automatic ext_pulse;
    @(posedge clk) ext_irq_n <= 1'b0;
    repeat (2) @(posedge clk);
    ext_irq_n <= 1'b1;
  endtask
  task automatic fire(input logic [6:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 7'h00;
  endtask
endmodule
`default_nettype wire

//--- rais_sequencer_tb.sv
// rais_sequencer_tb: bus and cpu strobe tests for the sequencer.
// assumes crystal option, level trigger, zero-wait ahb-lite slave.
`timescale 1ns/100ps
`default_nettype none
module rais_sequencer_tb;
  import rais_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic insn_end = 1'b0;
  logic exec_swi = 1'b0;
  logic exec_rti = 1'b0;
  logic exec_stop = 1'b0;
  logic exec_wait = 1'b0;
  logic rti_stacked_mask = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cpu_reset, cpu_run, osc_enable, stack_push, vector_fetch;
  logic global_mask_bit, timer_osc_oe_n;
  logic [12:0] vector_addr, sp_value;
  logic [15:0] timer_preset;
  wire logic rst_pin_n, ext_irq_n;
  wire logic [6:0] ev, ctl;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [12:0] vec [4] = '{VEC_EXT, VEC_TIMER, VEC_SERIAL, VEC_PORT_B};
  logic [7:0] sta [3] = '{OFS_TMR_STAT, OFS_SER_STAT, OFS_SPECIAL};
  logic [7:0] dat [3] = '{OFS_TMR_DATA, OFS_SER_DATA, OFS_PORT_B};
  logic [31:0] setv [3] = '{32'h20, 32'h80, 32'h82};
  logic [31:0] clrv [3] = '{32'h0, 32'h0, 32'h2};
  always #5 clk = ~clk;
  rais_partner rais_partner_inst (.*);
  rais_sequencer rais_sequencer_inst (
    .*, .capture_event(ev[0]), .compare_event(ev[1]), .overflow_event(ev[2]),
    .transfer_done_event(ev[3]), .write_collision_event(ev[4]), .mode_fault_event(ev[5]),
    .port_b_interrupt(ev[6]), .hsize(3'b010), .hready(hreadyout),
    .compare_output_pin(ctl[6]), .compare_output_level(ctl[5]), .serial_enable(ctl[4]),
    .serial_master_select(ctl[3]), .serial_open_drain(ctl[2]), .port_a_open_drain(ctl[1]),
    .timer_osc_enable(ctl[0])
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // hold each phase until hready is sampled high; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
  endtask
  task automatic cpu(input logic [3:0] op, input logic stacked);
    @(posedge clk);
    insn_end <= 1'b1;
    {exec_swi, exec_rti, exec_stop, exec_wait} <= op;
    rti_stacked_mask <= stacked;
    @(posedge clk);
    insn_end <= 1'b0;
    {exec_swi, exec_rti, exec_stop, exec_wait} <= 4'h0;
  endtask
  // bounded wait for the vector fetch pulse, n = edges waited
  task automatic take(input logic [12:0] v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (vector_fetch !== 1'b1 && n < 5000);
    check("vector_addr", 32'(v), 32'(vector_addr));
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic s;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    check("mask", 32'h1, 32'(global_mask_bit));
    check("sp", 32'hFF, 32'(sp_value));
    check("preset", 32'hFFFC, 32'(timer_preset));
    check("osc tristate", 32'h1, 32'(timer_osc_oe_n));
    take(VEC_RESET, n);
    check("startup", 32'h1, 32'(n >= 4064 && n <= 4068));
    $display("test power_on done");
    wr(OFS_SER_CTRL, 32'h70);
    wr(OFS_TMR_CTRL, 32'h1);
    wr(OFS_SPECIAL, 32'h5);
    wr(OFS_CLK_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    check("controls set", 32'h3F, 32'(ctl));
    rais_partner_inst.pin_reset(4200);
    take(VEC_RESET, n);
    check("pin release", 32'h1, 32'(n <= 6));
    check("controls", 32'h0, 32'(ctl));
    rdchk("special", OFS_SPECIAL, 32'h0);
    rdchk("ser_ctrl", OFS_SER_CTRL, 32'h0);
    rdchk("tmr_ctrl", OFS_TMR_CTRL, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    $display("test pin_reset done");
    for (int i = 1; i >= 0; i--) begin
      cpu(4'h8, 1'b0);
      take(VEC_TRAP, n);
      check("trap latency", 32'h2, 32'(n));
      cpu(4'h4, i[0]);
      @(posedge clk);
      check("mask", 32'(i[0]), 32'(global_mask_bit));
    end
    $display("test trap done");
    rais_partner_inst.fire(7'h04);
    cpu(4'h0, 1'b0);
    s = 1'b0;
    repeat (4) begin
      @(posedge clk);
      s = s | stack_push;
    end
    check("blocked push", 32'h0, 32'(s));
    wr(OFS_TMR_CTRL, 32'h60);
    wr(OFS_SER_CTRL, 32'h80);
    wr(OFS_SPECIAL, 32'h2);
    rais_partner_inst.fire(7'h48);
    rais_partner_inst.ext_pulse();
    for (int i = 0; i < 4; i++) begin
      cpu(4'h0, 1'b0);
      take(vec[i], n);
      if (i > 0) begin
        rdchk("flag kept", dat[i-1], 32'h0);
        rdchk("flag set", sta[i-1], setv[i-1]);
        rdchk("data", dat[i-1], 32'h0);
        rdchk("flag clear", sta[i-1], clrv[i-1]);
      end
      if (i < 3) begin
        cpu(4'h4, 1'b0);
      end
    end
    $display("test priority done");
    cpu(4'h1, 1'b0);
    repeat (3) @(posedge clk);
    check("wait run", 32'h0, 32'(cpu_run));
    check("wait mask", 32'h0, 32'(global_mask_bit));
    rais_partner_inst.fire(7'h02);
    take(VEC_TIMER, n);
    rdchk("compare flag", OFS_TMR_STAT, 32'h40);
    rdchk("data", OFS_TMR_DATA, 32'h0);
    $display("test wait done");
    wr(OFS_SPECIAL, 32'h6);
    cpu(4'h2, 1'b0);
    repeat (3) @(posedge clk);
    check("stop osc", 32'h0, 32'(osc_enable));
    check("stop mask", 32'h0, 32'(global_mask_bit));
    rais_partner_inst.ext_pulse();
    take(VEC_EXT, n);
    check("short exit", 32'h1, 32'(n <= 12));
    check("osc back", 32'h1, 32'(osc_enable));
    $display("test stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
